// ### hw/bmcdvm_top.sv
// Buck mode, discharge and core dynamic voltage ramp registers.
// Assumes a serial-bus front end that presents byte reads and writes synchronous to CORE_CLK.
// Notes on behaviour
// - Bit 3 selects efficient or low-ripple PFM
// - Bits 2..0 force PWM on system/core/memory
// - Control two resets 40h; launch cleared
// - Source select returns to one on resets
// - Launch ramps core to target at slew under register source; under pin source it waits
// - Launch clears when internal code reaches target
// - Source select picks register or pin
// - Pin low 1.2 V, pin high 1.45 V
// - Bits 2..0 enable output discharge when disabled
// - Five-bit target, upper bits read zero
// - Target resets on four events, pin default
// - Slew codes double; code 7 immediate
// - Slew resets 06h on lockout only
`include "bmcdvm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module bmcdvm_top
    import bmcdvm_pkg::*;
#(
    parameter int unsigned STEP_CYC_SLOWEST = `BMCDVM_STEP_CYC_SLOWEST
) (
    input  wire logic                        CORE_CLK,      // System clock
    input  wire logic                        ARST_N,        // Asynchronous reset, active low
    input  wire logic                        UNDERVOLTAGE_LOCKOUT_EVT,      // Undervoltage lockout, high active
    input  wire logic                        WARM_RESET_N,  // Warm reset input, active low
    input  wire logic                        POR_OUT_ACT,   // Power-on reset output active
    input  wire logic                        BACKUP_LOW,    // Backup supply below threshold
    input  wire bmcdvm_pkg::bmcdvm_pin_t     CFG_PIN,       // Core configuration pin level
    input  wire logic                        WR_EN,         // Register write strobe
    input  wire logic                        RD_EN,         // Register read strobe
    input  wire logic [7:0]                  ADDR,          // Register address
    input  wire logic [7:0]                  WDATA,         // Write data
    output logic [7:0]                       RDATA,         // Read data, one cycle after RD_EN
    output bmcdvm_pkg::bmcdvm_buck_ctl_t     BUCK_CTL,      // Mode and discharge controls
    output logic                             CORE_FROM_PIN, // Core voltage set by pin
    output logic [4:0]                       CORE_CODE      // Internal core voltage code
);
    import bmcdvm_pkg::*;

    // ==================================================
    // Register state
    logic [7:0]    mode_r;
    logic          launch_r;
    logic          srcsel_r;
    logic [2:0]    dis_r;
    logic [4:0]    target_r;
    logic [2:0]    slew_r;
    logic [4:0]    code_r;
    logic [4:0]    code_nxt;
    logic [16:0]   tick_r;
    logic [16:0]   tick_nxt;
    logic [16:0]   step_cyc;
    logic          step_hit;
    logic [7:0]    rdata_nxt;
    logic [4:0]    pin_default;
    logic          sys_reset;
    logic          ramp_done;
    bmcdvm_state_t state_r;

    // Any of the four system events restores the source and target
    // Events are levels: while one holds, writes to its fields are lost
    assign sys_reset   = UNDERVOLTAGE_LOCKOUT_EVT | ~WARM_RESET_N | POR_OUT_ACT | BACKUP_LOW;

    // Divider strap not modelled; anything but tied high reads as tied low
    always_comb begin
        pin_default = `BMCDVM_CORE_PIN_GND;
        if (CFG_PIN == BMCDVM_PIN_VCC) begin
            pin_default = `BMCDVM_CORE_PIN_VCC;
        end
    end

    // Each slower code doubles the interval between 25 mV steps
    assign step_cyc = 17'(STEP_CYC_SLOWEST >> slew_r);

    // ==================================================
    // Write address decode; unmapped offsets select nothing
    logic          wr_mode;
    logic          wr_ctrl2;
    logic          wr_core;
    logic          wr_slew;

    always_comb begin
        wr_mode  = 1'b0;
        wr_ctrl2 = 1'b0;
        wr_core  = 1'b0;
        wr_slew  = 1'b0;
        if (WR_EN) begin
            if (ADDR == `BMCDVM_OFS_MODE) begin
                wr_mode = 1'b1;
            end else if (ADDR == `BMCDVM_OFS_CTRL2) begin
                wr_ctrl2 = 1'b1;
            end else if (ADDR == `BMCDVM_OFS_CORE) begin
                wr_core = 1'b1;
            end else if (ADDR == `BMCDVM_OFS_SLEW) begin
                wr_slew = 1'b1;
            end
        end
    end

    // ==================================================
    // Mode register
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mode_r <= `BMCDVM_RST_MODE;
        end else if (UNDERVOLTAGE_LOCKOUT_EVT) begin
            mode_r <= `BMCDVM_RST_MODE;
        end else if (wr_mode) begin
            mode_r <= WDATA;
        end
    end

    // ==================================================
    // Control two: discharge and source select
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dis_r <= 3'h0;
        end else if (UNDERVOLTAGE_LOCKOUT_EVT) begin
            dis_r <= 3'h0;
        end else if (wr_ctrl2) begin
            dis_r <= WDATA[2:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            srcsel_r <= 1'b1;
        end else if (sys_reset) begin
            srcsel_r <= 1'b1;
        end else if (wr_ctrl2) begin
            srcsel_r <= WDATA[`BMCDVM_BIT_SRCSEL];
        end
    end

    // Launch: a new write of one wins over completion in the same cycle
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            launch_r <= 1'b0;
        end else if (UNDERVOLTAGE_LOCKOUT_EVT) begin
            launch_r <= 1'b0;
        end else if (wr_ctrl2 && WDATA[`BMCDVM_BIT_LAUNCH]) begin
            launch_r <= 1'b1;
        end else if (ramp_done) begin
            launch_r <= 1'b0;
        end
    end

    // ==================================================
    // Target and slew
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            target_r <= `BMCDVM_CORE_PIN_GND;
        end else if (sys_reset) begin
            target_r <= pin_default;
        end else if (wr_core) begin
            target_r <= WDATA[4:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            slew_r <= `BMCDVM_RST_SLEW;
        end else if (UNDERVOLTAGE_LOCKOUT_EVT) begin
            slew_r <= `BMCDVM_RST_SLEW;
        end else if (wr_slew) begin
            slew_r <= WDATA[2:0];
        end
    end

    // ==================================================
    // Ramp engine
    always_comb begin
        code_nxt = code_r;
        if (slew_r == `BMCDVM_SLEW_IMMED) begin
            code_nxt = target_r;
        end else if (code_r < target_r) begin
            code_nxt = code_r + 5'h1;
        end else if (code_r > target_r) begin
            code_nxt = code_r - 5'h1;
        end
    end

    assign ramp_done = (state_r == BMCDVM_RAMP) && (code_r == target_r);

    // Immediate slew bypasses the interval counter
    assign step_hit = (slew_r == `BMCDVM_SLEW_IMMED) || (tick_r + 17'h1 >= step_cyc);

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= BMCDVM_IDLE;
        end else if (sys_reset) begin
            state_r <= BMCDVM_IDLE;
        end else begin
            case (state_r)
                BMCDVM_IDLE: begin
                    // A launch left pending under pin control starts once registers rule
                    if (launch_r && !srcsel_r) begin
                        state_r <= BMCDVM_RAMP;
                    end
                end
                BMCDVM_RAMP: begin
                    if (code_r == target_r) begin
                        state_r <= BMCDVM_IDLE;
                    end
                end
                default: begin
                    // Stray code falls back to idle
                    state_r <= BMCDVM_IDLE;
                end
            endcase
        end
    end

    // ==================================================
    // Step interval counter
    // Restarts on every step and whenever idle, so each step waits a full interval
    always_comb begin
        tick_nxt = tick_r + 17'h1;
        if (state_r != BMCDVM_RAMP || step_hit) begin
            tick_nxt = 17'h0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tick_r <= 17'h0;
        end else if (sys_reset) begin
            tick_r <= 17'h0;
        end else begin
            tick_r <= tick_nxt;
        end
    end

    // Pin source tracks the strap default; register source follows the ramp
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            code_r <= `BMCDVM_CORE_PIN_GND;
        end else if (sys_reset || srcsel_r) begin
            code_r <= pin_default;
        end else if (state_r == BMCDVM_RAMP && code_r != target_r && step_hit) begin
            code_r <= code_nxt;
        end
    end

    // ==================================================
    // Read port; unmapped addresses read zero
    // Mux follows ADDR freely; only the read strobe loads RDATA
    always_comb begin
        rdata_nxt = 8'h00;
        if (ADDR == `BMCDVM_OFS_MODE) begin
            rdata_nxt = mode_r;
        end else if (ADDR == `BMCDVM_OFS_CTRL2) begin
            rdata_nxt = {launch_r, srcsel_r, 3'h0, dis_r};
        end else if (ADDR == `BMCDVM_OFS_CORE) begin
            rdata_nxt = {3'h0, target_r};
        end else if (ADDR == `BMCDVM_OFS_SLEW) begin
            rdata_nxt = {5'h00, slew_r};
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RDATA <= 8'h00;
        end else if (RD_EN) begin
            RDATA <= rdata_nxt;
        end
    end

    // ==================================================
    // Converter controls, one cycle behind the registers
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            BUCK_CTL <= '0;
        end else begin
            BUCK_CTL.low_ripple <= mode_r[`BMCDVM_BIT_LOWRIP];
            BUCK_CTL.fpwm_sys   <= mode_r[`BMCDVM_BIT_FPWM_SYS];
            BUCK_CTL.fpwm_core  <= mode_r[`BMCDVM_BIT_FPWM_CORE];
            BUCK_CTL.fpwm_mem   <= mode_r[`BMCDVM_BIT_FPWM_MEM];
            BUCK_CTL.dis_sys    <= dis_r[2];
            BUCK_CTL.dis_core   <= dis_r[1];
            BUCK_CTL.dis_mem    <= dis_r[0];
        end
    end

    // ==================================================
    // Core source and code outputs
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CORE_FROM_PIN <= 1'b1;
        end else begin
            CORE_FROM_PIN <= srcsel_r;
        end
    end

    // Code leaves through a flop so the converter never sees a mux glitch
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CORE_CODE <= `BMCDVM_CORE_PIN_GND;
        end else begin
            CORE_CODE <= code_r;
        end
    end
endmodule : bmcdvm_top
`default_nettype wire

// ### hw/bmcdvm_defs.svh
// Offsets, field positions, reset values and ramp timing of the buck mode and core voltage registers.
// Assumes inclusion by its bare name from the top module and the checker.
`ifndef BMCDVM_DEFS_SVH
`define BMCDVM_DEFS_SVH
`define BMCDVM_OFS_MODE        8'h04
`define BMCDVM_OFS_CTRL2       8'h05
`define BMCDVM_OFS_CORE        8'h06
`define BMCDVM_OFS_SLEW        8'h07
`define BMCDVM_RST_MODE        8'hB1
`define BMCDVM_RST_CTRL2       8'h40
`define BMCDVM_RST_SLEW        3'h6
`define BMCDVM_BIT_LOWRIP      3
`define BMCDVM_BIT_FPWM_SYS    2
`define BMCDVM_BIT_FPWM_CORE   1
`define BMCDVM_BIT_FPWM_MEM    0
`define BMCDVM_BIT_LAUNCH      7
`define BMCDVM_BIT_SRCSEL      6
`define BMCDVM_CORE_PIN_GND    5'h14
`define BMCDVM_CORE_PIN_VCC    5'h1E
`define BMCDVM_SLEW_IMMED      3'h7
// Step 25 mV at 0.225 mV/us is 111.1 us; at 40 MHz that is 4444 cycles, rounded down
`define BMCDVM_STEP_NS_SLOWEST 111111
`define BMCDVM_CLK_NS          25
`define BMCDVM_STEP_CYC_SLOWEST (`BMCDVM_STEP_NS_SLOWEST / `BMCDVM_CLK_NS)
`endif

// ### hw/bmcdvm_pkg.sv
// Types shared by the buck mode and core voltage register block.
// Assumes the constants header is compiled alongside.
package bmcdvm_pkg;
    typedef enum logic [1:0] {
        BMCDVM_PIN_GND = 2'h1, // Configuration pin tied low
        BMCDVM_PIN_VCC = 2'h2  // Configuration pin tied high
    } bmcdvm_pin_t;
    typedef struct packed {
        logic low_ripple;
        logic fpwm_sys;
        logic fpwm_core;
        logic fpwm_mem;
        logic dis_sys;
        logic dis_core;
        logic dis_mem;
    } bmcdvm_buck_ctl_t;
    typedef enum logic [1:0] {
        BMCDVM_IDLE = 2'b01,
        BMCDVM_RAMP = 2'b10
    } bmcdvm_state_t;
endpackage : bmcdvm_pkg

// ### bench/bmcdvm_checker.sv
// Port-level checker for the buck mode and core voltage registers.
// Assumes the top's ports only; bound to every top instance.
`timescale 1ns/1ps
`default_nettype none
`include "bmcdvm_defs.svh"
module bmcdvm_checker
    import bmcdvm_pkg::*;
#(
    parameter int unsigned STEP_CYC_SLOWEST = 64
) (
    input wire logic                    CORE_CLK,      // Clock
    input wire logic                    ARST_N,        // Reset, active low
    input wire logic                    UNDERVOLTAGE_LOCKOUT_EVT,      // Lockout
    input wire logic                    WARM_RESET_N,  // Warm reset, active low
    input wire logic                    POR_OUT_ACT,   // Power-on reset active
    input wire logic                    BACKUP_LOW,    // Backup supply low
    input wire bmcdvm_pkg::bmcdvm_pin_t CFG_PIN,       // Config pin
    input wire logic                    WR_EN,         // Write strobe
    input wire logic                    RD_EN,         // Read strobe
    input wire logic [7:0]              ADDR,          // Address
    input wire logic [7:0]              WDATA,         // Write data
    input wire logic [7:0]              RDATA,         // Read data
    input wire bmcdvm_pkg::bmcdvm_buck_ctl_t BUCK_CTL, // Controls
    input wire logic                    CORE_FROM_PIN, // Pin source
    input wire logic [4:0]              CORE_CODE      // Core code
);
    // ====================
    // Properties
    wire rst_ev = UNDERVOLTAGE_LOCKOUT_EVT | !WARM_RESET_N | POR_OUT_ACT | BACKUP_LOW;
    // Lockout restores the mode default, whose low nibble is not all zero
    localparam logic [7:0] MODE_DFLT = `BMCDVM_RST_MODE;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    // Lockout wins over every write, any event over source writes, so only quiet writes count
    sequence wr_s(a); WR_EN && ADDR == a && !rst_ev ##1 !rst_ev; endsequence
    mode_ctl_a: assert property (wr_s(8'h04) |=> BUCK_CTL[6:3] == $past(WDATA[3:0], 2))
        else $error("mode write not on controls");
    disch_ctl_a: assert property (wr_s(8'h05) |=> BUCK_CTL[2:0] == $past(WDATA[2:0], 2))
        else $error("discharge write not on controls");
    src_wr_a: assert property (wr_s(8'h05) |=> CORE_FROM_PIN == $past(WDATA[6], 2))
        else $error("source select write lost");
    undervoltage_lockout_clr_a: assert property (UNDERVOLTAGE_LOCKOUT_EVT[*2] |=> BUCK_CTL == {MODE_DFLT[3:0], 3'h0})
        else $error("lockout left controls set");
    ev_src_a: assert property (rst_ev[*2] |=> CORE_FROM_PIN)
        else $error("event did not restore pin source");
    ev_code_a: assert property (rst_ev[*3] ##0 $stable(CFG_PIN) |=>
        CORE_CODE == (CFG_PIN == BMCDVM_PIN_VCC ? 5'h1E : 5'h14)) else $error("code not pin default");
    core_rsvd_a: assert property (RD_EN && ADDR == 8'h06 |=> RDATA[7:5] == 3'h0)
        else $error("target upper bits not zero");
    slew_rsvd_a: assert property (RD_EN && ADDR == 8'h07 |=> RDATA[7:3] == 5'h00)
        else $error("slew upper bits not zero");
endmodule : bmcdvm_checker
bind bmcdvm_top bmcdvm_checker #(.STEP_CYC_SLOWEST(STEP_CYC_SLOWEST)) bmcdvm_checker_i (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .UNDERVOLTAGE_LOCKOUT_EVT(UNDERVOLTAGE_LOCKOUT_EVT), .WARM_RESET_N(WARM_RESET_N),
    .POR_OUT_ACT(POR_OUT_ACT), .BACKUP_LOW(BACKUP_LOW), .CFG_PIN(CFG_PIN), .WR_EN(WR_EN),
    .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .BUCK_CTL(BUCK_CTL),
    .CORE_FROM_PIN(CORE_FROM_PIN), .CORE_CODE(CORE_CODE));
`default_nettype wire

// ### bench/bmcdvm_host.sv
// Host model issuing byte reads and writes on the register strobes.
// Assumes a free-running clock; idle strobes are low, idle address and data carry inverted last values.
`timescale 1ns/1ps
`default_nettype none
module bmcdvm_host (
    input  wire logic       clk,   // Clock
    output logic            wr_en, // Write strobe
    output logic            rd_en, // Read strobe
    output logic [7:0]      addr,  // Address
    output logic [7:0]      wdata, // Write data
    input  wire logic [7:0] rdata  // Read data
);
    // ====================
    // Transfers
    initial {wr_en, rd_en, addr, wdata} = 18'h0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        #2;
        {wr_en, rd_en, addr, wdata} = {w, !w, a, d};
        @(posedge clk);
        #2;
        {wr_en, rd_en, addr, wdata} = {2'b00, ~a, ~d};
        // Read data holds until the next read strobe
        @(posedge clk);
        q = rdata;
    endtask : xfer
endmodule : bmcdvm_host
`default_nettype wire

// ### bench/bmcdvm_top_test.sv
// Self-checking bench for the buck mode and core voltage registers.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module bmcdvm_top_test;
    import bmcdvm_pkg::*;
    // ====================
    // Signals and helpers
    localparam int unsigned STEP = 64;
    logic             clk, arst_n, undervoltage_lockout, warm_n, por, bkup, wr_en, rd_en, from_pin;
    logic [7:0]       addr, wdata, rdata, a, d, m, c2;
    logic [7:0]       dflt [5] = '{8'hB1, 8'h40, 8'h14, 8'h06, 8'h00};
    logic [2:0]       slews [4] = '{3'h4, 3'h0, 3'h6, 3'h7};
    logic [4:0]       code, start, t;
    logic [15:0]      seed = 16'd31767;
    bmcdvm_pin_t      pin;
    bmcdvm_buck_ctl_t ctl;
    int               n_errors = 0, total_checks = 0, cycles = 0, cnt, lo, n;
    bmcdvm_top #(.STEP_CYC_SLOWEST(STEP)) bmcdvm_top_i (.CORE_CLK(clk), .ARST_N(arst_n), .UNDERVOLTAGE_LOCKOUT_EVT(undervoltage_lockout),
        .WARM_RESET_N(warm_n), .POR_OUT_ACT(por), .BACKUP_LOW(bkup), .CFG_PIN(pin), .WR_EN(wr_en),
        .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata), .RDATA(rdata), .BUCK_CTL(ctl), .CORE_FROM_PIN(from_pin),
        .CORE_CODE(code));
    bmcdvm_host bmcdvm_host_i (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
        .rdata(rdata));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [7:0] rmask(input logic [7:0] ad);
        return ad == 8'h04 ? 8'hFF : ad == 8'h05 ? 8'hC7 : ad == 8'h06 ? 8'h1F : 8'h07;
    endfunction : rmask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
        logic [7:0] q;
        bmcdvm_host_i.xfer(1'b0, ad, 8'h00, q);
        chk(q, exp);
    endtask : rd
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        logic [7:0] q;
        bmcdvm_host_i.xfer(1'b1, ad, dt, q);
    endtask : wr
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Ceiling well above the longest slow ramp
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end
    // ====================
    // Scenarios
    initial begin
        {arst_n, undervoltage_lockout, por, bkup, warm_n} = 5'b00001;
        pin = BMCDVM_PIN_GND;
        repeat (4) @(posedge clk);
        #2 arst_n = 1'b1;
        foreach (dflt[i]) rd(8'h04 + 8'(i), dflt[i]);
        $display("test defaults done");
        {m, c2} = 16'hB140;
        repeat (24) begin
            seed = lfsr(seed);
            a = 8'h04 + 8'(seed[1:0]);
            d = seed[15:8] & (a == 8'h05 ? 8'h7F : 8'hFF);
            if (a == 8'h04) m = d;
            if (a == 8'h05) c2 = d;
            wr(a, d);
            rd(a, d & rmask(a));
            chk({1'b0, ctl}, {1'b0, m[3:0], c2[2:0]});
        end
        $display("test readback done");
        wr(8'h05, 8'h00);
        foreach (slews[i]) begin
            seed = lfsr(seed);
            start = code;
            t = seed[4:0];
            wr(8'h07, {5'h00, slews[i]});
            wr(8'h06, {3'h0, t});
            wr(8'h05, 8'h80);
            n = t > start ? t - start : start - t;
            cnt = 0;
            while (code !== t && cnt < 2500) begin
                @(posedge clk);
                cnt++;
            end
            lo = n * (STEP >> slews[i]);
            chk(8'(cnt >= lo - 3 && cnt <= lo + n + 8), 8'h01);
            repeat (4) @(posedge clk);
            rd(8'h05, 8'h00);
        end
        start = code;
        wr(8'h06, {3'h0, ~code});
        wr(8'h05, 8'h00);
        repeat (8) @(posedge clk);
        chk({3'h0, code}, {3'h0, start});
        $display("test ramp done");
        for (int e = 0; e < 4; e++) begin
            pin = e[0] ? BMCDVM_PIN_VCC : BMCDVM_PIN_GND;
            wr(8'h07, 8'h03);
            wr(8'h05, 8'h05);
            #2 {warm_n, por, bkup, undervoltage_lockout} = {e != 0, e == 1, e == 2, e == 3};
            repeat (3) @(posedge clk);
            #2 {warm_n, por, bkup, undervoltage_lockout} = 4'b1000;
            rd(8'h05, e == 3 ? 8'h40 : 8'h45);
            rd(8'h06, e[0] ? 8'h1E : 8'h14);
            rd(8'h07, e == 3 ? 8'h06 : 8'h03);
            chk({3'h0, code}, e[0] ? 8'h1E : 8'h14);
            chk({7'h00, from_pin}, 8'h01);
            if (e == 3) chk({1'b0, ctl}, 8'h08);
            if (e == 3) rd(8'h04, 8'hB1);
        end
        $display("test reset events done");
        conclude();
    end
endmodule : bmcdvm_top_test
`default_nettype wire
